// file: hdl/sps_standby_pins.sv
// Standby pin state control for one general-purpose port
// Operation
// R1: Stop or watch with hold select clear keeps previous output and blocks input gate.
// R2: Stop or watch with hold select set floats output, pull-up stays in effect.
// R3: With hold select set, the input gate of floated pins is blocked too.
// R4: Interrupt-capable pins keep interrupt input while that interrupt is enabled.
// R5: One hold select bit in standby control governs both stop and watch.
// R6: A blocked input no longer reaches internal logic.
// R7: In reset pins float; digital inputs enabled, analog-shared inputs blocked.
`timescale 1ns/1ns
`include "sps_regs.svh"
module sps_standby_pins #(
  parameter int PINS = `SPS_PIN_COUNT,
  parameter logic [PINS-1:0] EXT_INT_PINS = '0,
  parameter logic [PINS-1:0] ANALOG_PINS = '0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire sps_pkg::sps_mode_t mode,
  input wire logic standby_pin_hold_select,
  input wire logic [PINS-1:0] port_out,
  input wire logic [PINS-1:0] port_oe_n,
  input wire logic [PINS-1:0] pull_up_en,
  input wire logic [PINS-1:0] ext_int_en,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  output logic [PINS-1:0] pin_pull_en,
  output logic [PINS-1:0] core_in,
  output logic [PINS-1:0] ext_int_in
);
  logic hold_sel_q, hold_sel_d;
  logic standby_q, standby_d;
  logic [PINS-1:0] out_q, out_d, oe_n_q, oe_n_d, pull_q, pull_d;
  logic [PINS-1:0] core_q, core_d, int_q, int_d;
  logic live_q, live_d;

  function automatic logic is_standby(input sps_pkg::sps_mode_t m);
    return (m == sps_pkg::SPS_STOP) || (m == sps_pkg::SPS_WATCH);
  endfunction

  always_comb begin
    hold_sel_d = standby_pin_hold_select; // R5
    standby_d = is_standby(mode); // R5
    out_d = out_q;
    oe_n_d = oe_n_q;
    pull_d = pull_up_en;
    core_d = pin_in;
    int_d = pin_in & EXT_INT_PINS;
    live_d = 1'b1;
    if (standby_d) begin
      if (standby_pin_hold_select) begin
        oe_n_d = '1; // R2
        pull_d = pull_up_en; // R2
      end else if (!standby_q) begin
        out_d = port_out; // R1
        oe_n_d = port_oe_n; // R1
      end
      core_d = '0; // R1 R3 R6
      int_d = pin_in & EXT_INT_PINS & ext_int_en; // R4
    end else begin
      out_d = port_out;
      oe_n_d = port_oe_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_sel_q <= `SPS_HOLD_RESET;
      standby_q <= 1'b0;
      out_q <= '0;
      oe_n_q <= '1; // R7
      pull_q <= '0;
      core_q <= '0;
      int_q <= '0;
      live_q <= 1'b0;
    end else begin
      hold_sel_q <= hold_sel_d;
      standby_q <= standby_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      pull_q <= pull_d;
      core_q <= core_d;
      int_q <= int_d;
      live_q <= live_d;
    end
  end

  always_comb begin
    pin_out = out_q;
    pin_oe_n = reset ? '1 : oe_n_q; // R7
    pin_pull_en = pull_q;
    // Digital pins pass input in reset, analog-shared ones do not
    core_in = reset ? (pin_in & ~ANALOG_PINS) : core_q; // R7
    ext_int_in = int_q;
  end

  // Steps of run, standby entry and standby stay
  sequence run_steady_s;
    live_q && !standby_q;
  endsequence

  sequence standby_steady_s;
    live_q && standby_q && $past(standby_q);
  endsequence

  sequence hold_entry_s;
    live_q && standby_q && !$past(standby_q) && !hold_sel_q;
  endsequence

  sequence float_entry_s;
    live_q && standby_q && !$past(standby_q) && hold_sel_q;
  endsequence

  sequence hold_steady_s;
    live_q && standby_q && $past(standby_q) && !hold_sel_q;
  endsequence

  // Standby hold and float
  hold_float_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q && hold_sel_q |-> pin_oe_n == '1) // R2
    else $error("Pins not floated with hold select set");

  gate_block_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q |-> core_in == '0) // R6
    else $error("Input gate open in standby");

  hold_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q && $past(standby_q) && !hold_sel_q && !$past(hold_sel_q)
      |-> $stable(pin_out) && $stable(pin_oe_n)) // R1
    else $error("Held output changed in standby");

  int_path_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q |-> (ext_int_in & ~($past(ext_int_en) & EXT_INT_PINS)) == '0) // R4
    else $error("Interrupt path open while disabled");

  int_pass_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q |-> ext_int_in == ($past(pin_in) & $past(ext_int_en) & EXT_INT_PINS)) // R4
    else $error("Enabled interrupt not passed");

  float_block_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q && hold_sel_q |-> core_in == '0 && pin_oe_n == '1) // R3
    else $error("Floated pin input not blocked");

  pull_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q && hold_sel_q |-> pin_pull_en == $past(pull_up_en)) // R2
    else $error("Pull-up not applied while floating");

  mode_track_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(is_standby(mode)) |-> standby_q) // R5
    else $error("Standby state not tracked");

  hold_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
    hold_entry_s |-> pin_out == $past(port_out) && pin_oe_n == $past(port_oe_n)) // R1
    else $error("Hold value not captured on entry");

  float_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
    float_entry_s |-> pin_oe_n == '1 && core_in == '0) // R2
    else $error("Pins not floated on entry");

  standby_out_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_steady_s |-> $stable(pin_out)) // R1
    else $error("Output value moved in standby");

  hold_oe_a: assert property (@(posedge ref_clk) disable iff (reset)
    hold_steady_s |-> $stable(pin_oe_n)) // R1
    else $error("Drive enable moved while holding");

  hold_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    standby_q && !hold_sel_q |-> core_in == '0) // R1
    else $error("Input gate open while holding");

  sel_track_a: assert property (@(posedge ref_clk) disable iff (reset)
    live_q |-> hold_sel_q == $past(standby_pin_hold_select)) // R5
    else $error("Hold select not tracked");

  // Run and sleep pass through
  run_out_a: assert property (@(posedge ref_clk) disable iff (reset)
    run_steady_s |-> pin_out == $past(port_out) && pin_oe_n == $past(port_oe_n)) // R5
    else $error("Port drive not passed in run");

  run_core_a: assert property (@(posedge ref_clk) disable iff (reset)
    run_steady_s |-> core_in == $past(pin_in)) // R6
    else $error("Pin input not passed in run");

  run_int_a: assert property (@(posedge ref_clk) disable iff (reset)
    run_steady_s |-> ext_int_in == ($past(pin_in) & EXT_INT_PINS)) // R4
    else $error("Interrupt input not passed in run");

  pull_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
    live_q |-> pin_pull_en == $past(pull_up_en)) // R2
    else $error("Pull-up setting not followed");

  standby_exit_a: assert property (@(posedge ref_clk) disable iff (reset)
    live_q && !$past(is_standby(mode)) |-> !standby_q) // R5
    else $error("Standby state left set");

  sleep_run_a: assert property (@(posedge ref_clk) disable iff (reset)
    live_q && $past(mode) == sps_pkg::SPS_SLEEP |-> !standby_q) // R5
    else $error("Sleep treated as standby");

  nonint_block_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ext_int_in & ~EXT_INT_PINS) == '0) // R4
    else $error("Interrupt path on plain pin");

  // Reset
  reset_float_a: assert property (@(posedge ref_clk)
    reset |-> pin_oe_n == '1 && (core_in & ANALOG_PINS) == '0) // R7
    else $error("Reset pin state wrong");

  reset_digital_a: assert property (@(posedge ref_clk)
    reset |-> (core_in & ~ANALOG_PINS) == (pin_in & ~ANALOG_PINS)) // R7
    else $error("Digital input not enabled in reset");

  reset_clear_a: assert property (@(posedge ref_clk)
    $past(reset) |-> pin_pull_en == '0 && ext_int_in == '0 && !standby_q) // R7
    else $error("State not cleared by reset");

  reset_sel_a: assert property (@(posedge ref_clk)
    $past(reset) |-> hold_sel_q == `SPS_HOLD_RESET) // R7
    else $error("Hold select not cleared by reset");

endmodule

// file: inc/sps_pkg.sv
// Types for the standby pin state control block
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_RUN = 2'b00,
    SPS_SLEEP = 2'b01,
    SPS_STOP = 2'b10,
    SPS_WATCH = 2'b11
  } sps_mode_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_en;
  } sps_drive_t;
endpackage

// file: inc/sps_regs.svh
// Constants for the standby pin state control block
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_PIN_COUNT 8
`define SPS_HOLD_RESET 1'b0
`define SPS_MODE_WIDTH 2
`endif

// file: verification/tb_top.sv
// Testbench for the standby pin state control block
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  sps_pkg::sps_mode_t mode = sps_pkg::SPS_RUN;
  logic sel = 1'b0;
  logic [7:0] p_out = 8'h00, p_oe_n = 8'hff, pull = 8'h00, ie = 8'h00, p_in = 8'hff;
  logic [7:0] o_out, o_oe_n, o_pull, o_core, o_int;
  int errors = 0;
  int check_count = 0;
  always #10 ref_clk = ~ref_clk;
  sps_standby_pins #(.PINS(8), .EXT_INT_PINS(8'h0f), .ANALOG_PINS(8'h03)) uut (
    .ref_clk(ref_clk), .reset(reset), .mode(mode), .standby_pin_hold_select(sel),
    .port_out(p_out), .port_oe_n(p_oe_n), .pull_up_en(pull), .ext_int_en(ie), .pin_in(p_in),
    .pin_out(o_out), .pin_oe_n(o_oe_n), .pin_pull_en(o_pull), .core_in(o_core),
    .ext_int_in(o_int));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Apply one set of inputs at an edge, then sample after the next edge
  task automatic drive(input sps_pkg::sps_mode_t m, input logic s,
                       input logic [7:0] o, oe, pu, en, pi);
    @(posedge ref_clk);
    mode <= m;
    sel <= s;
    p_out <= o;
    p_oe_n <= oe;
    pull <= pu;
    ie <= en;
    p_in <= pi;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    #1;
    chk(o_oe_n, 8'hff);
    chk(o_core, 8'hfc);
    @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task automatic t_standby(input sps_pkg::sps_mode_t m);
    drive(sps_pkg::SPS_RUN, 1'b0, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h96);
    chk(o_core, 8'h96);
    drive(m, 1'b0, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h96);
    drive(m, 1'b0, 8'h5a, 8'hff, 8'hc3, 8'h05, 8'hff);
    chk(o_out, 8'ha5);
    chk(o_oe_n, 8'h00);
    chk(o_core, 8'h00);
    chk(o_int, 8'h05);
    drive(m, 1'b1, 8'h5a, 8'h00, 8'h3c, 8'h0a, 8'hff);
    chk(o_oe_n, 8'hff);
    chk(o_pull, 8'h3c);
    chk(o_core, 8'h00);
    chk(o_int, 8'h0a);
    drive(m, 1'b0, 8'h33, 8'h00, 8'h3c, 8'h0a, 8'hff);
    chk(o_oe_n, 8'hff);
    chk(o_out, 8'ha5);
  endtask
  task automatic t_mid_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(o_oe_n, 8'hff);
    chk(o_core, 8'h3c);
    chk(o_pull, 8'h00);
    chk(o_int, 8'h00);
    @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task automatic t_wake();
    drive(sps_pkg::SPS_SLEEP, 1'b1, 8'h69, 8'h0f, 8'h00, 8'h00, 8'h3c);
    chk(o_out, 8'h69);
    chk(o_oe_n, 8'h0f);
    chk(o_core, 8'h3c);
    chk(o_int, 8'h0c);
  endtask
  task automatic wrap_up();
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    t_reset();
    t_standby(sps_pkg::SPS_STOP);
    t_standby(sps_pkg::SPS_WATCH);
    t_wake();
    t_mid_reset();
    wrap_up();
  end
endmodule
